// ===== rtl/bcd_parallel_readout_port.sv
/*
 Parallel six digit decimal readout port of a weighing meter.
 Latches readings on the meter update pulse, drives them with a
 jumper chosen enable scheme, a polarity option and a point code.
 Assumes all inputs are synchronous to clk_in.
*/
`timescale 1ns/1ns

module bcd_parallel_readout_port
	import bcd_port_pkg::*;
#(
	parameter int MARKER_LEN = `MARKER_CYCLES
) (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        update_pulse_in,
	input  wire reading_t    net_in,
	input  wire reading_t    gross_in,
	input  wire reading_t    tare_in,
	input  wire reading_t    peak_in,
	input  wire reading_t    valley_in,
	input  wire logic [2:0]  source_select_in,
	input  wire logic        compat_setting_in,
	input  wire logic        compat_write_in,
	input  wire logic        compat_lock_bit_in,
	input  wire jumpers_t    jumpers_in,
	input  wire logic        freeze_input_line_n_in,
	input  wire logic        first_enable_line_in,
	input  wire logic        second_enable_line_in,
	input  wire logic        third_address_line_in,
	input  wire logic        fourth_address_line_in,
	output logic [23:0]      digit_lines_out,
	output logic [23:0]      digit_lines_oe_n_out,
	output logic             sign_line_out,
	output logic             sign_line_oe_n_out,
	output logic             point_code_bit_a_out,
	output logic             point_code_bit_b_out,
	output logic             point_code_bit_c_out,
	output logic             point_oe_n_out,
	output logic             overflow_output_line_out,
	output logic             overflow_output_line_oe_n_out,
	output logic             update_marker_line_n_out,
	output logic             compat_setting_out
);

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		reading_t            latched;
		logic                pending;
		logic                compat;
		marker_state_t       mk_state;
		logic [31:0]         mk_count;
		logic [23:0]         lines;
		logic [23:0]         lines_oe_n;
		logic                sign;
		logic                sign_oe_n;
		logic [`POINT_W-1:0] point;
		logic                point_oe_n;
		logic                ovf;
		logic                ovf_oe_n;
		logic                marker_n;
	} state_t;

	state_t s_q;
	state_t s_d;

	// Applies the polarity strap to a data field
	function automatic logic [23:0] pol24(input logic [23:0] v,
		input logic inv);
		pol24 = inv ? ~v : v;
	endfunction

	// Picks the reading named by the source select setting
	function automatic reading_t pick(input logic [2:0] sel,
		input reading_t n, input reading_t g, input reading_t t,
		input reading_t p, input reading_t v);
		case (sel)
			`SRC_NET:    pick = n;
			`SRC_GROSS:  pick = g;
			`SRC_TARE:   pick = t;
			`SRC_PEAK:   pick = p;
			`SRC_VALLEY: pick = v;
			default:     pick = '0;
		endcase
	endfunction

	// Combinational enable decode; inputs are already synchronous
	logic     up_en;
	logic     lo_en;
	logic     card_en;
	logic     inv;
	logic     mux_mode;
	logic [3:0] addr_match;
	reading_t src;
	logic [`POINT_W-1:0] pcode;

	always_comb begin
		// Low on the polarity strap selects the inverted position
		inv = ~jumpers_in.polarity_jumper;
		mux_mode = jumpers_in.multiplex_jumper_one &
			jumpers_in.multiplex_jumper_two;
		// Invert jumper fitted means low enables
		up_en = first_enable_line_in ^
			jumpers_in.first_enable_invert_jumper;
		lo_en = ~up_en & (second_enable_line_in ^
			jumpers_in.second_enable_invert_jumper);
		// Bit order 1,2,4,8: first, second, fourth, third line
		addr_match[0] = first_enable_line_in ^
			jumpers_in.first_enable_invert_jumper;
		addr_match[1] = second_enable_line_in ^
			jumpers_in.second_enable_invert_jumper;
		addr_match[2] = fourth_address_line_in ^
			jumpers_in.fourth_address_invert_jumper;
		addr_match[3] = third_address_line_in ^
			jumpers_in.third_address_invert_jumper;
		if (jumpers_in.single_line_enable_jumper) begin
			card_en = addr_match[0];
		end else begin
			card_en = &addr_match;
		end
		src = pick(source_select_in, net_in, gross_in, tare_in,
			peak_in, valley_in);
		// Compat code: the point shifted up one, then ones complemented
		pcode = s_q.compat ?
			~(s_q.latched.point + 3'h1) :
			s_q.latched.point;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		// Setting accepted only while unlocked
		if (compat_write_in && !compat_lock_bit_in) begin
			s_d.compat = compat_setting_in;
		end
		// Latch the whole reading at once; freeze defers it
		if (update_pulse_in || s_q.pending) begin
			if (!freeze_input_line_n_in) begin
				s_d.pending = 1'b1;
			end else begin
				s_d.latched = src;
				s_d.pending = 1'b0;
				s_d.mk_state = MK_PULSE;
				s_d.mk_count = '0;
			end
		end
		// Marker sequencer, independent of polarity strap
		case (s_q.mk_state)
			MK_IDLE: begin
				s_d.marker_n = 1'b1;
			end
			MK_PULSE: begin
				s_d.marker_n = 1'b0;
				// Count runs to the full length so the low time is exact
				if (s_q.mk_count >= 32'(MARKER_LEN)) begin
					s_d.mk_state = MK_IDLE;
					s_d.marker_n = 1'b1;
				end else begin
					s_d.mk_count = s_q.mk_count + 32'h1;
				end
				// Any latch, deferred ones too, restarts the marker
				if ((update_pulse_in || s_q.pending) &&
					freeze_input_line_n_in) begin
					s_d.mk_count = '0;
					s_d.mk_state = MK_PULSE;
					s_d.marker_n = 1'b0;
				end
			end
			default: begin
				s_d.mk_state = MK_IDLE;
				s_d.marker_n = 1'b1;
			end
		endcase
		// Digit lines, four weighted lines per digit
		if (mux_mode) begin
			s_d.lines[23:12] = '0;
			s_d.lines[11:0] = up_en ?
				s_q.latched.digits[5:3] :
				s_q.latched.digits[2:0];
			s_d.lines = pol24(s_d.lines, inv);
			s_d.lines_oe_n = {{`HALF_LINES{1'b1}},
				{`HALF_LINES{~(up_en | lo_en)}}};
			s_d.sign_oe_n = ~(up_en | lo_en);
			s_d.point_oe_n = ~(up_en | lo_en);
		end else begin
			s_d.lines = pol24(s_q.latched.digits, inv);
			s_d.lines_oe_n = {24{~card_en}};
			s_d.sign_oe_n = ~card_en;
			s_d.point_oe_n = ~card_en;
		end
		s_d.sign = s_q.latched.negative ^ inv;
		s_d.point = inv ? ~pcode : pcode;
		s_d.ovf = s_q.latched.overflow ^ inv;
		// Overflow line left floating unless routed
		s_d.ovf_oe_n = ~jumpers_in.overflow_route_jumper |
			s_d.sign_oe_n;
		if (srst_in) begin
			s_d = '0;
			s_d.latched.point = `POINT_RESET;
			s_d.mk_state = MK_IDLE;
			s_d.lines_oe_n = '1;
			s_d.sign_oe_n = 1'b1;
			s_d.point_oe_n = 1'b1;
			s_d.ovf_oe_n = 1'b1;
			s_d.marker_n = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		s_q <= s_d;
	end

	// Outputs straight from the state record
	assign digit_lines_out = s_q.lines;
	assign digit_lines_oe_n_out = s_q.lines_oe_n;
	assign sign_line_out = s_q.sign;
	assign sign_line_oe_n_out = s_q.sign_oe_n;
	assign point_code_bit_a_out = s_q.point[0];
	assign point_code_bit_b_out = s_q.point[1];
	assign point_code_bit_c_out = s_q.point[2];
	assign point_oe_n_out = s_q.point_oe_n;
	assign overflow_output_line_out = s_q.ovf;
	assign overflow_output_line_oe_n_out = s_q.ovf_oe_n;
	assign update_marker_line_n_out = s_q.marker_n;
	assign compat_setting_out = s_q.compat;

endmodule

// ===== rtl/bcd_port_defines.svh
/*
 Named constants for the parallel decimal readout port.
 Assumes inclusion by bare name; no processes live here.
*/
`ifndef BCD_PORT_DEFINES_SVH
`define BCD_PORT_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ        125000000
`define MARKER_TIME_US     200
`define MARKER_CYCLES      ((`CLK_FREQ_HZ / 1000000) * `MARKER_TIME_US)

// ----------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------
`define SRC_OFF            3'h0
`define SRC_NET            3'h1
`define SRC_GROSS          3'h2
`define SRC_TARE           3'h3
`define SRC_PEAK           3'h4
`define SRC_VALLEY         3'h5

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define DIGIT_W            4
`define POINT_W            3
`define POINT_RESET        3'h1
`define POINT_MAX          3'h7
`define HALF_LINES         12

`endif

// ===== rtl/bcd_port_pkg.sv
/*
 Types for the parallel decimal readout port.
 Assumes the defines header is visible to every user.
*/
`include "bcd_port_defines.svh"

package bcd_port_pkg;

	// One reading as six decimal digits plus flags
	typedef struct packed {
		logic [5:0][`DIGIT_W-1:0] digits;
		logic [`POINT_W-1:0]      point;
		logic                     negative;
		logic                     overflow;
	} reading_t;

	// Jumper straps of the option card
	typedef struct packed {
		logic overflow_route_jumper;
		logic multiplex_jumper_one;
		logic single_line_enable_jumper;
		logic multiplex_jumper_two;
		logic second_enable_invert_jumper;
		logic first_enable_invert_jumper;
		logic third_address_invert_jumper;
		logic fourth_address_invert_jumper;
		logic polarity_jumper;
	} jumpers_t;

	// Marker sequencer states
	typedef enum logic [1:0] {
		MK_IDLE  = 2'b01,
		MK_PULSE = 2'b10
	} marker_state_t;

endpackage

// ===== verification/bcd_port_asserts.sv
/* Checker bound to the readout port top module.
   Assumes every input is synchronous to clk_in. */
`timescale 1ns/1ns
module bcd_port_checker
	import bcd_port_pkg::*;
#(
	parameter int MARKER_LEN = 10
) (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        update_pulse_in,
	input wire logic        freeze_input_line_n_in,
	input wire jumpers_t    jumpers_in,
	input wire logic        first_enable_line_in,
	input wire logic        second_enable_line_in,
	input wire logic        third_address_line_in,
	input wire logic        fourth_address_line_in,
	input wire logic [23:0] digit_lines_out,
	input wire logic [23:0] digit_lines_oe_n_out,
	input wire logic        overflow_output_line_oe_n_out,
	input wire logic        update_marker_line_n_out
);
	jumpers_t    j;
	logic        mx, sl, up, lo, ad;
	logic [15:0] low_q;
	// Enable decode for each strap set
	assign j = jumpers_in;
	assign mx = j.multiplex_jumper_one & j.multiplex_jumper_two;
	assign sl = !mx & j.single_line_enable_jumper;
	assign up = first_enable_line_in ^ j.first_enable_invert_jumper;
	assign lo = second_enable_line_in ^ j.second_enable_invert_jumper;
	assign ad = !mx & !sl & up & lo
		& (third_address_line_in ^ j.third_address_invert_jumper)
		& (fourth_address_line_in ^ j.fourth_address_invert_jumper);
	// Marker low time, counted so the width is checked exactly
	always_ff @(posedge clk_in) begin
		low_q <= (srst_in | update_marker_line_n_out) ? 16'h0 : low_q + 16'h1;
	end
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	freeze_hold_a: assert property (
		(!freeze_input_line_n_in)[*3] |=> $stable(digit_lines_out))
		else $error("lines moved while frozen");
	marker_start_a: assert property (
		update_pulse_in && freeze_input_line_n_in
		|-> ##2 !update_marker_line_n_out) else $error("no marker");
	marker_width_a: assert property (
		$rose(update_marker_line_n_out) |-> low_q == 16'(MARKER_LEN))
		else $error("marker width wrong");
	single_en_a: assert property (
		sl && up |=> digit_lines_oe_n_out == 24'h0) else $error("not driven");
	addr_hit_a: assert property (
		ad |=> digit_lines_oe_n_out == 24'h0) else $error("address not on");
	addr_miss_a: assert property (
		!mx && !sl && !ad |=> &digit_lines_oe_n_out
		&& overflow_output_line_oe_n_out) else $error("drives on miss");
	mux_upper_a: assert property (
		mx && up |=> digit_lines_oe_n_out == {12'hfff, 12'h0})
		else $error("upper half off");
	ovf_route_a: assert property (
		!j.overflow_route_jumper |=> overflow_output_line_oe_n_out)
		else $error("overflow driven");
	cover property (ad);
	cover property (mx && !up && lo);
	cover property ($fell(freeze_input_line_n_in));
endmodule

bind bcd_parallel_readout_port bcd_port_checker #(.MARKER_LEN(MARKER_LEN))
	bcd_port_checker_i (.*);

// ===== verification/bcd_reader_model.sv
/* Reader on the port: a logger that selects the card by address.
   Assumes the bench sets the address code. */
`timescale 1ns/1ns
module bcd_reader_model (
	input  wire logic [3:0]  code_in,
	input  wire logic [23:0] lines_in,
	input  wire logic [23:0] oe_n_in,
	output logic             first_line_out,
	output logic             second_line_out,
	output logic             third_line_out,
	output logic             fourth_line_out,
	output logic [23:0]      seen_out
);
	// Weights: first 1, second 2, fourth 4, third 8
	assign {third_line_out, fourth_line_out, second_line_out,
		first_line_out} = code_in;
	// Floating lines read high through the input pull-ups
	assign seen_out = lines_in | oe_n_in;
endmodule

// ===== verification/test_bcd_parallel_readout_port.sv
/* Bench for the readout port with a reader model on its lines.
   Assumes the package, checker and model are compiled first. */
`timescale 1ns/1ns
module test_bcd_parallel_readout_port;
	import bcd_port_pkg::*;
	logic        clk_in = 1'b0, srst_in = 1'b1, update_pulse_in = 1'b0;
	logic        compat_setting_in = 1'b1, compat_write_in = 1'b0;
	logic        compat_lock_bit_in = 1'b1, freeze_input_line_n_in = 1'b1;
	logic        first_enable_line_in, second_enable_line_in;
	logic        third_address_line_in, fourth_address_line_in;
	logic        sign_line_out, sign_line_oe_n_out, point_oe_n_out;
	logic        point_code_bit_a_out, point_code_bit_b_out;
	logic        point_code_bit_c_out, overflow_output_line_out;
	logic        overflow_output_line_oe_n_out, update_marker_line_n_out;
	logic        compat_setting_out;
	logic [2:0]  source_select_in = 3'h0, pt;
	logic [3:0]  code = 4'h0;
	logic [23:0] digit_lines_out, digit_lines_oe_n_out, seen, d;
	jumpers_t    jumpers_in = 9'h049;
	reading_t    rd [5];
	int          err_total = 0, checks = 0, cyc = 0;
	assign pt = {point_code_bit_c_out, point_code_bit_b_out,
		point_code_bit_a_out};
	bcd_parallel_readout_port #(.MARKER_LEN(10)) bcd_parallel_readout_port_i (
		.net_in(rd[0]), .gross_in(rd[1]), .tare_in(rd[2]), .peak_in(rd[3]),
		.valley_in(rd[4]), .*);
	bcd_reader_model bcd_reader_model_i (.code_in(code),
		.lines_in(digit_lines_out), .oe_n_in(digit_lines_oe_n_out),
		.first_line_out(first_enable_line_in),
		.second_line_out(second_enable_line_in),
		.third_line_out(third_address_line_in),
		.fourth_line_out(fourth_address_line_in), .seen_out(seen));
	// Clock and a hang guard well above the 181 cycles used
	always #4 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [23:0] v, input logic [23:0] e);
		checks++;
		if (v !== e) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, v, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	// Waits out the last marker, then lines are new two edges on
	task automatic upd;
		tick(11);
		update_pulse_in = 1'b1;
		tick(1);
		update_pulse_in = 1'b0;
		tick(1);
	endtask
	task automatic wr(input logic lk);
		compat_lock_bit_in = lk;
		compat_write_in = 1'b1;
		tick(1);
		compat_write_in = 1'b0;
		tick(1);
	endtask
	task automatic t_src;
		for (int s = 0; s < 6; s++) begin
			source_select_in = 3'(s);
			upd();
			chk(seen, s == 0 ? 24'h0 : rd[s-1].digits);
			chk({21'h0, pt}, s == 0 ? 24'h0 : {21'h0, rd[s-1].point});
		end
		$display("source test done");
	endtask
	task automatic t_frz;
		d = rd[1].digits;
		source_select_in = 3'h2;
		freeze_input_line_n_in = 1'b0;
		upd();
		tick(3);
		chk(seen, rd[4].digits);
		freeze_input_line_n_in = 1'b1;
		tick(2);
		chk(seen, d);
		$display("freeze test done");
	endtask
	task automatic t_pol;
		jumpers_in = 9'h048; // negative-true data
		upd();
		chk(seen, ~d);
		chk({21'h0, pt}, {21'h0, ~rd[1].point});
		chk({22'h0, sign_line_out, overflow_output_line_out},
			{22'h0, ~rd[1].negative, ~rd[1].overflow});
		chk({23'h0, update_marker_line_n_out}, 24'h0);
		tick(10);
		chk({23'h0, update_marker_line_n_out}, 24'h1);
		$display("polarity test done");
	endtask
	// Address straps: overflow routed, second and third lines inverted
	task automatic t_adr;
		jumpers_in = 9'h115;
		for (int c = 0; c < 16; c++) begin
			code = 4'(c);
			tick(2);
			chk(digit_lines_oe_n_out, c == 5 ? 24'h0 : 24'hffffff);
			chk({23'h0, overflow_output_line_oe_n_out}, {23'h0, c != 5});
		end
		$display("address test done");
	endtask
	task automatic t_mux;
		jumpers_in = 9'h0e9; // both mux straps, first line inverted
		code = 4'h0;
		tick(2);
		chk(seen, {12'hfff, d[23:12]});
		code = 4'h3;
		tick(2);
		chk(seen, {12'hfff, d[11:0]});
		code = 4'h1;
		tick(2);
		chk(seen, 24'hffffff);
		jumpers_in.first_enable_invert_jumper = 1'b0;
		tick(2);
		chk(seen, {12'hfff, d[23:12]});
		$display("multiplex test done");
	endtask
	task automatic t_cmp;
		jumpers_in = 9'h049;
		code = 4'h0;
		wr(1'b1);
		chk({23'h0, compat_setting_out}, 24'h0);
		wr(1'b0);
		chk({23'h0, compat_setting_out}, 24'h1);
		upd();
		chk({21'h0, pt}, {21'h0, ~(rd[1].point + 3'h1)});
		$display("compat test done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		for (int k = 0; k < 5; k++) begin
			rd[k] = {24'h987650 | 24'(k), 3'(k + 1), k[0], k[1]};
		end
		tick(5);
		srst_in = 1'b0;
		t_src();
		t_frz();
		t_pol();
		t_adr();
		t_mux();
		t_cmp();
		tally_and_finish();
	end
endmodule
